/* File: hdl/frc_pkg.sv */
// Shared constants, types and checksum function for the flow reading link
package frc_pkg;

   // Clock and serial clock timing
   localparam int CLK_NS       = 8;
   localparam int SCL_HALF_NS  = 1250;
   localparam int SCL_HALF_CYC = (SCL_HALF_NS / CLK_NS < 1) ? 1 : SCL_HALF_NS / CLK_NS;

   // Frame geometry
   localparam int WORD_W  = 16;
   localparam int CRC_W   = 8;
   localparam int CMD_W   = 8;
   localparam int FRAME_W = WORD_W + CRC_W;
   localparam int CNT_W   = 6;

   // Command bytes on the link
   localparam logic [CMD_W-1:0] CMD_FLOW = 8'h01;
   localparam logic [CMD_W-1:0] CMD_TEMP = 8'h02;
   localparam logic [CMD_W-1:0] CMD_UNIT = 8'h03;

   // Checksum definition
   localparam logic [CRC_W-1:0] CRC_POLY = 8'h31;
   localparam logic [CRC_W-1:0] CRC_INIT = 8'hFF;

   // Flow unit word layout
   localparam int UNIT_PREFIX_LSB = 0;
   localparam int UNIT_PREFIX_W   = 4;
   localparam int UNIT_TIME_LSB   = 4;
   localparam int UNIT_TIME_W     = 4;
   localparam int UNIT_BASE_LSB   = 8;
   localparam int UNIT_BASE_W     = 5;
   localparam int UNIT_USED_W     = UNIT_BASE_LSB + UNIT_BASE_W;

   // The single defined unit: standard liter per minute, multiplier one
   localparam logic [UNIT_BASE_W-1:0]   UNIT_BASE_SL   = 5'h01;
   localparam logic [UNIT_TIME_W-1:0]   UNIT_TIME_MIN  = 4'h4;
   localparam logic [UNIT_PREFIX_W-1:0] UNIT_PREFIX_1  = 4'h8;
   localparam logic [WORD_W-1:0]        UNIT_WORD_SLM  =
      {{(WORD_W-UNIT_USED_W){1'b0}}, UNIT_BASE_SL, UNIT_TIME_MIN, UNIT_PREFIX_1};

   // Conversion constants
   localparam int SCALE_W = 12;
   localparam logic [SCALE_W-1:0] FLOW_SCALE_20 = 12'h09C4;
   localparam logic [SCALE_W-1:0] FLOW_SCALE_50 = 12'h03E8;
   localparam logic [SCALE_W-1:0] TEMP_SCALE    = 12'h00C8;
   localparam logic [WORD_W-1:0]  FLOW_OFFSET   = 16'h9000;
   localparam logic [WORD_W-1:0]  TEMP_OFFSET   = 16'h0000;
   localparam logic [SCALE_W-1:0] OUT_MILLI     = 12'h03E8;
   localparam int VAL_W = 32;

   // Word selection, fitted variant and calibrated gas
   typedef enum logic [1:0] {FRC_SEL_FLOW, FRC_SEL_TEMP, FRC_SEL_UNIT} frc_sel_t;
   typedef enum logic {FRC_VAR_20, FRC_VAR_50} frc_variant_t;
   typedef enum logic [2:0] {
      FRC_GAS_O2, FRC_GAS_AIR, FRC_GAS_N2O, FRC_GAS_CO2,
      FRC_GAS_AIR_O2, FRC_GAS_N2O_O2, FRC_GAS_CO2_O2
   } frc_gas_t;

   // Checksum over one data word, high byte first, no reflection
   function automatic logic [CRC_W-1:0] crc8(input logic [WORD_W-1:0] data);
      logic [CRC_W-1:0] c;
      c = CRC_INIT;
      for (int i = WORD_W - 1; i >= 0; i--) begin
         if (c[CRC_W-1] ^ data[i]) begin
            c = {c[CRC_W-2:0], 1'b0} ^ CRC_POLY;
         end else begin
            c = {c[CRC_W-2:0], 1'b0};
         end
      end
      return c;
   endfunction

endpackage

/* File: hdl/frc_link_if.sv */
// Two-wire link between sensor end and host end, with open-drain data
`timescale 1ns/1ps
interface frc_link_if;
   logic scl;          // Serial clock, driven by host only
   logic host_sda_o;   // Host data out value
   logic host_sda_oe;  // Host pulls data line
   logic dev_sda_o;    // Sensor data out value
   logic dev_sda_oe;   // Sensor pulls data line
   logic sda;          // Resolved data line level

   // Pull-up: line is high unless an enabled driver pulls it
   assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

   modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
   modport dev  (input scl, output dev_sda_o, output dev_sda_oe, input sda);
endinterface

/* File: hdl/frc_device.sv */
// Sensor end: answers word requests with data word and checksum
`timescale 1ns/1ps
module frc_device (
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         reset,
   // Link
   frc_link_if.dev                           link,
   // Measurement inputs
   input  wire logic [frc_pkg::WORD_W-1:0]   flow_raw,
   input  wire logic [frc_pkg::WORD_W-1:0]   temp_raw,
   // Status
   output logic                              active_q,
   output logic                              bad_cmd_q
);

   typedef enum logic [1:0] {DV_IDLE, DV_CMD, DV_TX, DV_WAIT} frc_dev_st_t;

   frc_dev_st_t                     st_q, st_d;
   logic                            scl_p_q, sda_p_q;
   logic [frc_pkg::FRAME_W-1:0]     sh_q, sh_d;
   logic [frc_pkg::CNT_W-1:0]       cnt_q, cnt_d;
   logic                            oe_q, oe_d;
   logic                            bad_d, active_d;
   logic                            scl_rise, scl_fall, start_c, stop_c;
   logic [frc_pkg::CMD_W-1:0]       cmd_c;
   logic [frc_pkg::WORD_W-1:0]      word_c;

   // Open-drain: only ever pulls low
   assign link.dev_sda_o  = 1'b0;
   assign link.dev_sda_oe = oe_q;

   // Line events; start and stop only while clock stays high
   assign scl_rise = link.scl & ~scl_p_q;
   assign scl_fall = ~link.scl & scl_p_q;
   assign start_c  = link.scl & scl_p_q & sda_p_q & ~link.sda;
   assign stop_c   = link.scl & scl_p_q & ~sda_p_q & link.sda;
   assign cmd_c    = {sh_q[frc_pkg::CMD_W-2:0], link.sda};

   // Next state of the responder
   always_comb begin
      st_d   = st_q;
      sh_d   = sh_q;
      cnt_d  = cnt_q;
      oe_d   = oe_q;
      bad_d  = bad_cmd_q;
      word_c = '0;
      if (start_c) begin
         st_d  = DV_CMD;
         cnt_d = '0;
         oe_d  = 1'b0;
         bad_d = 1'b0;
      end else if (stop_c) begin
         st_d = DV_IDLE;
         oe_d = 1'b0;
      end else begin
         case (st_q)
            DV_CMD: begin
               if (scl_rise) begin
                  sh_d  = {sh_q[frc_pkg::FRAME_W-2:0], link.sda};
                  cnt_d = cnt_q + 1'b1;
                  if (cnt_q == frc_pkg::CNT_W'(frc_pkg::CMD_W - 1)) begin
                     cnt_d = '0;
                     st_d  = DV_TX;
                     // Words are latched here so the whole frame is coherent
                     case (cmd_c)
                        frc_pkg::CMD_FLOW: word_c = flow_raw;
                        frc_pkg::CMD_TEMP: word_c = temp_raw;
                        frc_pkg::CMD_UNIT: word_c = frc_pkg::UNIT_WORD_SLM;
                        default: begin
                           st_d  = DV_WAIT;
                           bad_d = 1'b1;
                        end
                     endcase
                     sh_d = {word_c, frc_pkg::crc8(word_c)};
                  end
               end
            end
            DV_TX: begin
               // Data changes only while clock is low
               if (scl_fall) begin
                  if (cnt_q == frc_pkg::CNT_W'(frc_pkg::FRAME_W)) begin
                     oe_d = 1'b0;
                     st_d = DV_WAIT;
                  end else begin
                     oe_d  = ~sh_q[frc_pkg::FRAME_W-1];
                     sh_d  = {sh_q[frc_pkg::FRAME_W-2:0], 1'b0};
                     cnt_d = cnt_q + 1'b1;
                  end
               end
            end
            DV_IDLE, DV_WAIT: begin
               st_d = st_q;
            end
            default: st_d = DV_IDLE;
         endcase
      end
      // Busy flag registered so the output comes from a flop
      active_d = (st_d != DV_IDLE);
   end

   // Responder registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_q      <= DV_IDLE;
         scl_p_q   <= 1'b1;
         sda_p_q   <= 1'b1;
         sh_q      <= '0;
         cnt_q     <= '0;
         oe_q      <= 1'b0;
         bad_cmd_q <= 1'b0;
         active_q  <= 1'b0;
      end else begin
         st_q      <= st_d;
         scl_p_q   <= link.scl;
         sda_p_q   <= link.sda;
         sh_q      <= sh_d;
         cnt_q     <= cnt_d;
         oe_q      <= oe_d;
         bad_cmd_q <= bad_d;
         active_q  <= active_d;
      end
   end

endmodule // frc_device

/* File: hdl/frc_host.sv */
// Host end: fetches words, checks checksum, converts to physical units
`timescale 1ns/1ps
module frc_host (
   // Clock and reset
   input  wire logic                                clk,
   input  wire logic                                reset,
   // Link
   frc_link_if.host                                 link,
   // Request
   input  wire logic                                go,
   input  wire frc_pkg::frc_sel_t                   sel,
   input  wire frc_pkg::frc_variant_t               variant,
   input  wire frc_pkg::frc_gas_t                   gas,
   // Result
   output logic                                     busy_q,
   output logic                                     done_q,
   output logic [frc_pkg::WORD_W-1:0]               raw_q,
   output logic                                     crc_ok_q,
   output logic                                     unsupported_q,
   output logic signed [frc_pkg::VAL_W-1:0]         value_q,
   output logic [frc_pkg::UNIT_PREFIX_W-1:0]        unit_prefix_q,
   output logic [frc_pkg::UNIT_TIME_W-1:0]          unit_time_q,
   output logic [frc_pkg::UNIT_BASE_W-1:0]          unit_base_q,
   output logic                                     unit_slm_q
);

   typedef enum logic [2:0] {HS_IDLE, HS_STA, HS_CMD, HS_RD, HS_STO, HS_CHK, HS_DIV, HS_FIN} frc_host_st_t;
   localparam int DIV_W = $clog2(frc_pkg::SCL_HALF_CYC + 1);

   frc_host_st_t                        st_q, st_d;
   logic [DIV_W-1:0]                    div_q, div_d;
   logic                                scl_q, scl_d;
   logic                                oe_q, oe_d;
   logic [frc_pkg::CMD_W-1:0]           cmd_q, cmd_d;
   logic [frc_pkg::FRAME_W-1:0]         sh_q, sh_d;
   logic [frc_pkg::CNT_W-1:0]           cnt_q, cnt_d;
   frc_pkg::frc_sel_t                   sel_q, sel_d;
   frc_pkg::frc_variant_t               var_q, var_d;
   frc_pkg::frc_gas_t                   gas_q, gas_d;
   logic [frc_pkg::VAL_W-1:0]           quo_q, quo_d;
   logic [frc_pkg::SCALE_W-1:0]         rem_q, rem_d;
   logic                                neg_q, neg_d;
   logic                                busy_d, done_d, crc_ok_d, unsup_d, slm_d;
   logic [frc_pkg::WORD_W-1:0]          raw_d;
   logic signed [frc_pkg::VAL_W-1:0]    value_d;
   logic [frc_pkg::UNIT_PREFIX_W-1:0]   pre_d;
   logic [frc_pkg::UNIT_TIME_W-1:0]     tb_d;
   logic [frc_pkg::UNIT_BASE_W-1:0]     base_d;
   logic                                tick;
   logic                                sup_c;
   logic [frc_pkg::SCALE_W-1:0]         scale_c;
   logic [frc_pkg::WORD_W-1:0]          off_c;
   logic signed [frc_pkg::WORD_W:0]     diff_c;
   logic signed [frc_pkg::VAL_W-1:0]    prod_c;
   logic [frc_pkg::SCALE_W:0]           trial_c;
   logic [frc_pkg::WORD_W-1:0]          word_c;

   // Open-drain data: host only pulls low
   assign link.scl         = scl_q;
   assign link.host_sda_o  = 1'b0;
   assign link.host_sda_oe = oe_q;
   assign word_c           = sh_q[frc_pkg::FRAME_W-1:frc_pkg::CRC_W];

   // Calibration constants for the request in hand
   always_comb begin
      sup_c   = 1'b1;
      scale_c = frc_pkg::TEMP_SCALE;
      off_c   = frc_pkg::TEMP_OFFSET;
      if (sel_q == frc_pkg::FRC_SEL_FLOW) begin
         off_c = frc_pkg::FLOW_OFFSET;
         if (var_q == frc_pkg::FRC_VAR_20) begin
            scale_c = frc_pkg::FLOW_SCALE_20;
            sup_c   = (gas_q <= frc_pkg::FRC_GAS_CO2_O2);
         end else begin
            scale_c = frc_pkg::FLOW_SCALE_50;
            sup_c   = (gas_q == frc_pkg::FRC_GAS_O2) || (gas_q == frc_pkg::FRC_GAS_AIR) ||
                      (gas_q == frc_pkg::FRC_GAS_AIR_O2);
         end
      end
   end

   // Signed difference scaled to thousandths before the divide
   assign diff_c  = $signed({word_c[frc_pkg::WORD_W-1], word_c}) -
                    $signed({off_c[frc_pkg::WORD_W-1], off_c});
   assign prod_c  = frc_pkg::VAL_W'(diff_c) * $signed({1'b0, frc_pkg::OUT_MILLI});
   assign trial_c = {rem_q, quo_q[frc_pkg::VAL_W-1]};

   // Half-period tick for the serial clock; rests while idle
   assign tick  = (div_q == DIV_W'(frc_pkg::SCL_HALF_CYC - 1));
   assign div_d = (st_q == HS_IDLE || tick) ? '0 : div_q + 1'b1;

   // Next state of the transfer and conversion engine
   always_comb begin
      st_d     = st_q;
      scl_d    = scl_q;
      oe_d     = oe_q;
      cmd_d    = cmd_q;
      sh_d     = sh_q;
      cnt_d    = cnt_q;
      sel_d    = sel_q;
      var_d    = var_q;
      gas_d    = gas_q;
      quo_d    = quo_q;
      rem_d    = rem_q;
      neg_d    = neg_q;
      busy_d   = busy_q;
      done_d   = 1'b0;
      raw_d    = raw_q;
      crc_ok_d = crc_ok_q;
      unsup_d  = unsupported_q;
      value_d  = value_q;
      pre_d    = unit_prefix_q;
      tb_d     = unit_time_q;
      base_d   = unit_base_q;
      slm_d    = unit_slm_q;
      case (st_q)
         HS_IDLE: begin
            if (go) begin
               // Start: pull data low while clock is high
               sel_d  = sel;
               var_d  = variant;
               gas_d  = gas;
               busy_d = 1'b1;
               oe_d   = 1'b1;
               st_d   = HS_STA;
               case (sel)
                  frc_pkg::FRC_SEL_TEMP: cmd_d = frc_pkg::CMD_TEMP;
                  frc_pkg::FRC_SEL_UNIT: cmd_d = frc_pkg::CMD_UNIT;
                  default:               cmd_d = frc_pkg::CMD_FLOW;
               endcase
            end
         end
         HS_STA: begin
            if (tick) begin
               scl_d = 1'b0;
               oe_d  = ~cmd_q[frc_pkg::CMD_W-1];
               cmd_d = {cmd_q[frc_pkg::CMD_W-2:0], 1'b0};
               cnt_d = '0;
               st_d  = HS_CMD;
            end
         end
         HS_CMD: begin
            if (tick) begin
               if (!scl_q) begin
                  scl_d = 1'b1;
               end else begin
                  scl_d = 1'b0;
                  if (cnt_q == frc_pkg::CNT_W'(frc_pkg::CMD_W - 1)) begin
                     oe_d  = 1'b0;
                     cnt_d = '0;
                     st_d  = HS_RD;
                  end else begin
                     oe_d  = ~cmd_q[frc_pkg::CMD_W-1];
                     cmd_d = {cmd_q[frc_pkg::CMD_W-2:0], 1'b0};
                     cnt_d = cnt_q + 1'b1;
                  end
               end
            end
         end
         HS_RD: begin
            // Sample on the rising clock; the sensor moved data while it was low
            if (tick) begin
               if (!scl_q) begin
                  scl_d = 1'b1;
                  sh_d  = {sh_q[frc_pkg::FRAME_W-2:0], link.sda};
               end else begin
                  scl_d = 1'b0;
                  if (cnt_q == frc_pkg::CNT_W'(frc_pkg::FRAME_W - 1)) begin
                     oe_d  = 1'b1;
                     cnt_d = '0;
                     st_d  = HS_STO;
                  end else begin
                     cnt_d = cnt_q + 1'b1;
                  end
               end
            end
         end
         HS_STO: begin
            // Stop: clock high first, then release data
            if (tick) begin
               if (cnt_q == '0) begin
                  scl_d = 1'b1;
                  cnt_d = cnt_q + 1'b1;
               end else begin
                  oe_d = 1'b0;
                  st_d = HS_CHK;
               end
            end
         end
         HS_CHK: begin
            raw_d    = word_c;
            crc_ok_d = (frc_pkg::crc8(word_c) == sh_q[frc_pkg::CRC_W-1:0]);
            unsup_d  = 1'b0;
            value_d  = '0;
            st_d     = HS_FIN;
            if (sel_q == frc_pkg::FRC_SEL_UNIT) begin
               // Upper three bits carry no meaning and are dropped
               pre_d  = word_c[frc_pkg::UNIT_PREFIX_LSB +: frc_pkg::UNIT_PREFIX_W];
               tb_d   = word_c[frc_pkg::UNIT_TIME_LSB +: frc_pkg::UNIT_TIME_W];
               base_d = word_c[frc_pkg::UNIT_BASE_LSB +: frc_pkg::UNIT_BASE_W];
               slm_d  = (word_c[frc_pkg::UNIT_USED_W-1:0] ==
                         frc_pkg::UNIT_WORD_SLM[frc_pkg::UNIT_USED_W-1:0]);
            end else if (!sup_c) begin
               unsup_d = 1'b1;
            end else if (crc_ok_d) begin
               neg_d = prod_c[frc_pkg::VAL_W-1];
               quo_d = prod_c[frc_pkg::VAL_W-1] ? frc_pkg::VAL_W'(-prod_c) : frc_pkg::VAL_W'(prod_c);
               rem_d = '0;
               cnt_d = '0;
               st_d  = HS_DIV;
            end
         end
         HS_DIV: begin
            // One quotient bit per cycle; small area over speed
            if (trial_c >= {1'b0, scale_c}) begin
               rem_d = frc_pkg::SCALE_W'(trial_c - {1'b0, scale_c});
               quo_d = {quo_q[frc_pkg::VAL_W-2:0], 1'b1};
            end else begin
               rem_d = trial_c[frc_pkg::SCALE_W-1:0];
               quo_d = {quo_q[frc_pkg::VAL_W-2:0], 1'b0};
            end
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == frc_pkg::CNT_W'(frc_pkg::VAL_W - 1)) begin
               st_d = HS_FIN;
            end
         end
         HS_FIN: begin
            if (cnt_q == frc_pkg::CNT_W'(frc_pkg::VAL_W)) begin
               value_d = neg_q ? -$signed(quo_q) : $signed(quo_q);
            end
            cnt_d  = '0;
            busy_d = 1'b0;
            done_d = 1'b1;
            st_d   = HS_IDLE;
         end
         default: st_d = HS_IDLE;
      endcase
   end

   // Engine and result registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_q          <= HS_IDLE;
         div_q         <= '0;
         scl_q         <= 1'b1;
         oe_q          <= 1'b0;
         cmd_q         <= '0;
         sh_q          <= '0;
         cnt_q         <= '0;
         sel_q         <= frc_pkg::FRC_SEL_FLOW;
         var_q         <= frc_pkg::FRC_VAR_20;
         gas_q         <= frc_pkg::FRC_GAS_O2;
         quo_q         <= '0;
         rem_q         <= '0;
         neg_q         <= 1'b0;
         busy_q        <= 1'b0;
         done_q        <= 1'b0;
         raw_q         <= '0;
         crc_ok_q      <= 1'b0;
         unsupported_q <= 1'b0;
         value_q       <= '0;
         unit_prefix_q <= '0;
         unit_time_q   <= '0;
         unit_base_q   <= '0;
         unit_slm_q    <= 1'b0;
      end else begin
         st_q          <= st_d;
         div_q         <= div_d;
         scl_q         <= scl_d;
         oe_q          <= oe_d;
         cmd_q         <= cmd_d;
         sh_q          <= sh_d;
         cnt_q         <= cnt_d;
         sel_q         <= sel_d;
         var_q         <= var_d;
         gas_q         <= gas_d;
         quo_q         <= quo_d;
         rem_q         <= rem_d;
         neg_q         <= neg_d;
         busy_q        <= busy_d;
         done_q        <= done_d;
         raw_q         <= raw_d;
         crc_ok_q      <= crc_ok_d;
         unsupported_q <= unsup_d;
         value_q       <= value_d;
         unit_prefix_q <= pre_d;
         unit_time_q   <= tb_d;
         unit_base_q   <= base_d;
         unit_slm_q    <= slm_d;
      end
   end

endmodule // frc_host

/* File: verif/frc_link_chk.sv */
// Concurrent checks on the two-wire link between host and sensor ends
`timescale 1ns/1ps
module frc_link_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Link signals
   input wire logic scl,
   input wire logic host_sda_o,
   input wire logic host_sda_oe,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic sda
);
   logic        scl_p_q;
   logic        sda_p_q;
   logic [5:0]  n_q;
   logic [7:0]  c_q;
   logic [31:0] sh_q;
   logic        start_w;
   logic        stop_w;
   logic        rise_w;

   // Line events from the previous sample of both wires
   assign start_w = scl_p_q & scl & sda_p_q & ~sda;
   assign stop_w  = scl_p_q & scl & ~sda_p_q & sda;
   assign rise_w  = ~scl_p_q & scl;

   // Own bit count and checksum; the stop bit rise is counted but not shifted
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         n_q     <= 6'h00;
         c_q     <= 8'hFF;
         sh_q    <= 32'h0000_0000;
      end else begin
         scl_p_q <= scl;
         sda_p_q <= sda;
         if (start_w) begin
            n_q <= 6'h00;
            c_q <= 8'hFF;
         end else if (rise_w && n_q < 6'h21) begin
            n_q <= n_q + 6'h01;
            if (n_q < 6'h20) sh_q <= {sh_q[30:0], sda};
            if (n_q >= 6'h08 && n_q < 6'h18) c_q <= {c_q[6:0], 1'b0} ^ ((c_q[7] ^ sda) ? 8'h31 : 8'h00);
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_low8; !scl [*8]; endsequence
   sequence s_high8; scl [*8]; endsequence

   a_open_drain: assert property (!host_sda_o && !dev_sda_o)
      else $error("data line driven high");
   a_idle_after_reset: assert property ($fell(reset) |-> scl && !host_sda_oe && !dev_sda_oe)
      else $error("link not idle after reset");
   a_scl_low_min: assert property ($fell(scl) |-> s_low8)
      else $error("clock low half too short");
   a_scl_high_min: assert property ($rose(scl) |-> s_high8)
      else $error("clock high half too short");
   a_scl_low_max: assert property ($fell(scl) |-> ##[1:200] $rose(scl))
      else $error("clock low half too long");
   a_dev_stable_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("sensor data moved while clock high");
   a_frame_length: assert property (stop_w |-> n_q == 6'h21)
      else $error("frame bit count wrong");
   a_cmd_known: assert property (stop_w |-> sh_q[31:24] inside {8'h01, 8'h02, 8'h03})
      else $error("unknown command byte");
   a_crc_on_wire: assert property (stop_w |-> sh_q[7:0] == c_q)
      else $error("checksum on wire wrong");
   a_unit_on_wire: assert property (stop_w && sh_q[31:24] == 8'h03 |-> sh_q[23:8] == 16'h0148)
      else $error("unit word on wire wrong");
endmodule // frc_link_chk

/* File: verif/test_flow_reading_conversion.sv */
// Testbench joining both link ends and checking conversions
`timescale 1ns/1ps
module test_flow_reading_conversion;
   logic                  clk, reset, go, active_q, bad_cmd_q, busy_q, done_q;
   logic                  crc_ok_q, unsupported_q, unit_slm_q;
   frc_pkg::frc_sel_t     sel;
   frc_pkg::frc_variant_t variant;
   frc_pkg::frc_gas_t     gas;
   logic [15:0]           flow_raw, temp_raw, raw_q;
   logic signed [31:0]    value_q;
   logic [3:0]            unit_prefix_q, unit_time_q;
   logic [4:0]            unit_base_q;
   int                    mismatches, checks;

   frc_link_if link ();
   frc_device frc_device_inst (.clk(clk), .reset(reset), .link(link), .flow_raw(flow_raw),
      .temp_raw(temp_raw), .active_q(active_q), .bad_cmd_q(bad_cmd_q));
   frc_host frc_host_inst (.clk(clk), .reset(reset), .link(link), .go(go), .sel(sel),
      .variant(variant), .gas(gas), .busy_q(busy_q), .done_q(done_q), .raw_q(raw_q),
      .crc_ok_q(crc_ok_q), .unsupported_q(unsupported_q), .value_q(value_q),
      .unit_prefix_q(unit_prefix_q), .unit_time_q(unit_time_q), .unit_base_q(unit_base_q),
      .unit_slm_q(unit_slm_q));
   frc_link_chk frc_link_chk_inst (.clk(clk), .reset(reset), .scl(link.scl),
      .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o),
      .dev_sda_oe(link.dev_sda_oe), .sda(link.sda));

   // Verdict and end of run
   task automatic conclude;
      if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Comparisons, one per result kind
   task automatic cmp_bit(input logic a, input logic e);
      checks++;
      if (a !== e) begin mismatches++; $display("[ERR] %0t flag mismatch", $time); end
   endtask
   task automatic cmp_word(input logic [15:0] a, input logic [15:0] e);
      checks++;
      if (a !== e) begin mismatches++; $display("[ERR] %0t word %h not %h", $time, a, e); end
   endtask
   task automatic cmp_val(input logic signed [31:0] a, input logic signed [31:0] e);
      checks++;
      if (a !== e) begin mismatches++; $display("[ERR] %0t value %0d not %0d", $time, a, e); end
   endtask

   // One request pulse, then a bounded wait for done
   task automatic run(input frc_pkg::frc_sel_t s, input frc_pkg::frc_variant_t v,
                      input frc_pkg::frc_gas_t g, input logic [15:0] f, input logic [15:0] t);
      int i;
      @(posedge clk); #1;
      sel = s; variant = v; gas = g; flow_raw = f; temp_raw = t; go = 1'b1;
      @(posedge clk); #1;
      go = 1'b0;
      cmp_bit(busy_q, 1'b1);
      for (i = 0; i < 20000; i++) begin
         @(posedge clk); #1;
         if (done_q === 1'b1) break;
      end
      if (i == 20000) begin mismatches++; $display("[ERR] %0t no done", $time); conclude(); end
      cmp_bit(busy_q, 1'b0);
      cmp_bit(active_q, 1'b0);
   endtask

   // 20 slm, mixture, positive flow with a truncated fraction
   task automatic t_flow20;
      run(frc_pkg::FRC_SEL_FLOW, frc_pkg::FRC_VAR_20, frc_pkg::FRC_GAS_CO2_O2, 16'hA000, 16'h0000);
      cmp_word(raw_q, 16'hA000);
      cmp_bit(crc_ok_q, 1'b1);
      cmp_bit(unsupported_q, 1'b0);
      cmp_val(value_q, (-24576 + 28672) * 1000 / 2500);
   endtask
   // 50 slm at the most negative reading
   task automatic t_flow50;
      run(frc_pkg::FRC_SEL_FLOW, frc_pkg::FRC_VAR_50, frc_pkg::FRC_GAS_AIR_O2, 16'h8000, 16'h0000);
      cmp_bit(unsupported_q, 1'b0);
      cmp_val(value_q, (-32768 + 28672) * 1000 / 1000);
   endtask
   // Gas without calibration on the 50 slm part
   task automatic t_unsup;
      run(frc_pkg::FRC_SEL_FLOW, frc_pkg::FRC_VAR_50, frc_pkg::FRC_GAS_N2O, 16'h7FFF, 16'h0000);
      cmp_bit(unsupported_q, 1'b1);
      cmp_val(value_q, 0);
   endtask
   // Negative temperature
   task automatic t_temp;
      run(frc_pkg::FRC_SEL_TEMP, frc_pkg::FRC_VAR_20, frc_pkg::FRC_GAS_O2, 16'h1234, 16'hFF38);
      cmp_word(raw_q, 16'hFF38);
      cmp_val(value_q, -200 * 1000 / 200);
   endtask
   // Unit word and its fields
   task automatic t_unit;
      run(frc_pkg::FRC_SEL_UNIT, frc_pkg::FRC_VAR_20, frc_pkg::FRC_GAS_O2, 16'h0000, 16'h0000);
      cmp_word(raw_q, 16'h0148);
      cmp_word({12'h000, unit_prefix_q}, 16'h0008);
      cmp_word({12'h000, unit_time_q}, 16'h0004);
      cmp_word({11'h000, unit_base_q}, 16'h0001);
      cmp_bit(unit_slm_q, 1'b1);
      cmp_bit(bad_cmd_q, 1'b0);
   endtask

   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Reset, then back-to-back requests
   initial begin
      reset = 1'b1; go = 1'b0; sel = frc_pkg::FRC_SEL_FLOW; variant = frc_pkg::FRC_VAR_20;
      gas = frc_pkg::FRC_GAS_O2; flow_raw = 16'h0000; temp_raw = 16'h0000; mismatches = 0; checks = 0;
      repeat (16) @(posedge clk);
      #1 reset = 1'b0;
      t_flow20();
      t_flow50();
      t_unsup();
      t_temp();
      t_unit();
      conclude();
   end
endmodule // test_flow_reading_conversion
